//--- ebl_params.svh
// Shared constants for the byte-lane steering unit and its lane swapper.
// Assumes a 32-bit data bus made of four 8-bit byte lanes.
`ifndef EBL_PARAMS_SVH
`define EBL_PARAMS_SVH

// Transfer-width codes driven on the bus, identical in both byte orders
`define EBL_SIZE_BYTE 2'h0
`define EBL_SIZE_HALF 2'h1
`define EBL_SIZE_WORD 2'h2

// Bus geometry
`define EBL_LANES     4
`define EBL_LANE_W    8
`define EBL_DATA_W    32

// Byte enables for the fixed lane groups
`define EBL_BE_NONE   4'h0
`define EBL_BE_LOW    4'h3
`define EBL_BE_HIGH   4'hC
`define EBL_BE_ALL    4'hF
`define EBL_BE_LANE0  4'h1

// Reset values of the configuration latches
`define EBL_RST_BIG   1'b0
`define EBL_RST_SWAP  1'b0

`endif

//--- ebl_pkg.sv
// Types shared by the byte-lane steering unit.
// Assumes ebl_params.svh supplies the numeric constants.
`default_nettype none

package ebl_pkg;

  // Bus transaction sequencing
  typedef enum logic {
    EBL_IDLE,
    EBL_WAIT
  } ebl_state_t;

endpackage : ebl_pkg

`default_nettype wire

//--- ebl_lane_swap.sv
// Programmable lane swapper: lane n maps to lane LANES-1-n when enabled.
// Assumes swap_on_in is static after reset, never changed per transfer.
`timescale 1ns/1ps
`default_nettype none

module ebl_lane_swap #(
  parameter int LANES  = 4,
  parameter int LANE_W = 8
) (
  // Control
  input  wire logic                      swap_on_in,
  // Data
  input  wire logic [LANES*LANE_W-1:0]   lanes_in,
  output logic      [LANES*LANE_W-1:0]   lanes_out
);

  // One mux per lane; the same mapping serves every transfer size
  genvar n;
  generate
    for (n = 0; n < LANES; n = n + 1) begin : g_lane
      assign lanes_out[n*LANE_W +: LANE_W] = swap_on_in ?
        lanes_in[(LANES-1-n)*LANE_W +: LANE_W] :
        lanes_in[n*LANE_W +: LANE_W];
    end
  endgenerate

endmodule : ebl_lane_swap

`default_nettype wire

//--- ebl_steer.sv
// Contract
// - Byte order latched from strap at power-up
// - Big: address 0 on 31-24; little on 7-0; with the lane swap on, big uses 7-0 and little 31-24
// - Big mode offset-1 byte from bits 23-16; from 15-8 with the lane swap on
// - Little mode offset-1 byte from bits 15-8; from 23-16 with the lane swap on
// - Unsigned byte load zero-fills upper bits
// - Address and width code mode independent
// - Bit numbering within words never changes; the lane swap, when on, reverses the four byte lanes
// - Fetches are full words, never steered; the lane swap, when on, still reverses their byte lanes
//
// Byte-lane steering between a processor load/store port and an IO bus.
// Assumes straps are stable around reset release and the bus answers
// every request with one bus_ack_in pulse.
`timescale 1ns/1ps
`default_nettype none
`include "ebl_params.svh"

module ebl_steer #(
  parameter int DATA_W = `EBL_DATA_W
) (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  // Configuration straps
  input  wire logic              cfg_big_endian_in,
  input  wire logic              cfg_swap_in,
  // Processor request
  input  wire logic              cpu_req_in,
  input  wire logic              cpu_fetch_in,
  input  wire logic              cpu_write_in,
  input  wire logic              cpu_signed_in,
  input  wire logic [1:0]        cpu_size_in,
  input  wire logic [31:0]       cpu_addr_in,
  input  wire logic [DATA_W-1:0] cpu_wdata_in,
  // Processor answer
  output logic                   cpu_ready_out,
  output logic                   cpu_done_out,
  output logic      [DATA_W-1:0] cpu_rdata_out,
  output logic                   big_endian_out,
  output logic                   swap_on_out,
  // IO bus
  output logic                   bus_req_out,
  output logic                   bus_write_out,
  output logic      [1:0]        bus_size_out,
  output logic      [31:0]       bus_addr_out,
  output logic      [3:0]        bus_be_out,
  output logic      [DATA_W-1:0] bus_wdata_out,
  input  wire logic              bus_ack_in,
  input  wire logic [DATA_W-1:0] bus_rdata_in
);

  ebl_pkg::ebl_state_t state;
  logic              cfg_done;
  logic              accept;
  logic [1:0]        req_off;
  logic [1:0]        req_size;
  logic              req_fetch;
  logic              req_signed;
  logic [1:0]        next_size;
  logic [3:0]        next_be;
  logic [DATA_W-1:0] next_wdata;
  logic [3:0]        swap_be;
  logic [DATA_W-1:0] swap_wdata;
  logic [DATA_W-1:0] swap_rdata;
  logic [DATA_W-1:0] next_rdata;

  // Straps caught on the first edge after release, not under reset
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_done       <= 1'b0;
      big_endian_out <= `EBL_RST_BIG;
      swap_on_out    <= `EBL_RST_SWAP;
    end else if (!cfg_done) begin
      cfg_done       <= 1'b1;
      big_endian_out <= cfg_big_endian_in;
      swap_on_out    <= cfg_swap_in;
    end
  end

  // No request is taken until the byte order is known
  assign cpu_ready_out = cfg_done && (state == ebl_pkg::EBL_IDLE);
  assign accept        = cpu_req_in && cpu_ready_out;

  // Fetches always go out as words; width code ignores byte order
  always_comb begin
    next_size = cpu_fetch_in ? `EBL_SIZE_WORD : cpu_size_in;
  end

  // Lane enables: big order counts lanes from the top, little from 0
  always_comb begin
    next_be = `EBL_BE_ALL;
    if (!cpu_fetch_in) begin
      case (cpu_size_in)
        `EBL_SIZE_BYTE: begin
          next_be = big_endian_out ?
            (`EBL_BE_LANE0 << (~cpu_addr_in[1:0])) :
            (`EBL_BE_LANE0 << cpu_addr_in[1:0]);
        end
        `EBL_SIZE_HALF: begin
          next_be = (big_endian_out ^ cpu_addr_in[1]) ?
            `EBL_BE_HIGH : `EBL_BE_LOW;
        end
        default: begin
          next_be = `EBL_BE_ALL;
        end
      endcase
    end
  end

  // Replicating narrow data onto every lane keeps the byte order out of
  // the write path; the enables alone pick the live lane
  always_comb begin
    case (next_size)
      `EBL_SIZE_BYTE: next_wdata = {4{cpu_wdata_in[7:0]}};
      `EBL_SIZE_HALF: next_wdata = {2{cpu_wdata_in[15:0]}};
      default:        next_wdata = cpu_wdata_in;
    endcase
  end

  // Swapper on the IO side, same mapping for data, enables and reads
  ebl_lane_swap #(
    .LANES  (`EBL_LANES),
    .LANE_W (`EBL_LANE_W)
  ) u_swap_wdata (
    .swap_on_in (swap_on_out),
    .lanes_in   (next_wdata),
    .lanes_out  (swap_wdata)
  );

  ebl_lane_swap #(
    .LANES  (`EBL_LANES),
    .LANE_W (1)
  ) u_swap_be (
    .swap_on_in (swap_on_out),
    .lanes_in   (next_be),
    .lanes_out  (swap_be)
  );

  ebl_lane_swap #(
    .LANES  (`EBL_LANES),
    .LANE_W (`EBL_LANE_W)
  ) u_swap_rdata (
    .swap_on_in (swap_on_out),
    .lanes_in   (bus_rdata_in),
    .lanes_out  (swap_rdata)
  );

  // Read extraction: pick the lane for the offset, then extend
  always_comb begin
    logic [1:0] lane;
    logic       half;
    lane       = big_endian_out ? ~req_off : req_off;
    half       = big_endian_out ? ~req_off[1] : req_off[1];
    next_rdata = swap_rdata;
    if (!req_fetch) begin
      case (req_size)
        `EBL_SIZE_BYTE: begin
          next_rdata = {{24{req_signed && swap_rdata[lane*8+7]}},
                        swap_rdata[lane*8 +: 8]};
        end
        `EBL_SIZE_HALF: begin
          next_rdata = {{16{req_signed && swap_rdata[half*16+15]}},
                        swap_rdata[half*16 +: 16]};
        end
        default: begin
          next_rdata = swap_rdata;
        end
      endcase
    end
  end

  // Transaction sequencing
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ebl_pkg::EBL_IDLE;
    end else begin
      case (state)
        ebl_pkg::EBL_IDLE: if (accept) state <= ebl_pkg::EBL_WAIT;
        ebl_pkg::EBL_WAIT: if (bus_ack_in) state <= ebl_pkg::EBL_IDLE;
        default:           state <= ebl_pkg::EBL_IDLE;
      endcase
    end
  end

  // Bus request registers; address passes untouched in both orders
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_req_out   <= 1'b0;
      bus_write_out <= 1'b0;
      bus_size_out  <= `EBL_SIZE_WORD;
      bus_addr_out  <= 32'h0000_0000;
      bus_be_out    <= `EBL_BE_NONE;
      bus_wdata_out <= '0;
    end else if (accept) begin
      bus_req_out   <= 1'b1;
      bus_write_out <= cpu_write_in && !cpu_fetch_in;
      bus_size_out  <= next_size;
      bus_addr_out  <= cpu_addr_in;
      bus_be_out    <= swap_be;
      bus_wdata_out <= swap_wdata;
    end else if (bus_ack_in && state == ebl_pkg::EBL_WAIT) begin
      bus_req_out   <= 1'b0;
    end
  end

  // Request details kept for the read extraction
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_off    <= 2'h0;
      req_size   <= `EBL_SIZE_WORD;
      req_fetch  <= 1'b0;
      req_signed <= 1'b0;
    end else if (accept) begin
      req_off    <= cpu_addr_in[1:0];
      req_size   <= next_size;
      req_fetch  <= cpu_fetch_in;
      req_signed <= cpu_signed_in;
    end
  end

  // Answer to the processor, one pulse per completed transfer
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cpu_done_out  <= 1'b0;
      cpu_rdata_out <= '0;
    end else begin
      cpu_done_out <= bus_ack_in && state == ebl_pkg::EBL_WAIT;
      if (bus_ack_in && state == ebl_pkg::EBL_WAIT) begin
        cpu_rdata_out <= next_rdata;
      end
    end
  end

  // Checks
  property p_cfg_first;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !cfg_done |-> !cpu_ready_out ##1 cfg_done;
  endproperty
  a_cfg_first: assert property (p_cfg_first)
    else $error("request window opened before straps");

  property p_cfg_hold;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    cfg_done |=> $stable(big_endian_out) && $stable(swap_on_out);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("byte order or swap changed after reset");

  property p_addr_size;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    accept |=> bus_req_out && bus_addr_out == $past(cpu_addr_in) &&
      bus_size_out == ($past(cpu_fetch_in) ? `EBL_SIZE_WORD :
                       $past(cpu_size_in));
  endproperty
  a_addr_size: assert property (p_addr_size)
    else $error("bus address or width code wrong");

  property p_byte_lane;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    accept && !cpu_fetch_in && cpu_size_in == `EBL_SIZE_BYTE &&
      !swap_on_out && cpu_addr_in[1:0] == 2'h0 |=>
      bus_be_out == (big_endian_out ? 4'h8 : 4'h1);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("byte 0 on wrong lane");

  property p_off1_big;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    state == ebl_pkg::EBL_WAIT && bus_ack_in && big_endian_out &&
      !swap_on_out && !req_fetch && req_size == `EBL_SIZE_BYTE &&
      req_off == 2'h1 |=>
      cpu_rdata_out[7:0] == $past(bus_rdata_in[23:16]);
  endproperty
  a_off1_big: assert property (p_off1_big)
    else $error("big offset-1 byte not from 23-16");

  property p_off1_little;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    state == ebl_pkg::EBL_WAIT && bus_ack_in && !big_endian_out &&
      !swap_on_out && !req_fetch && req_size == `EBL_SIZE_BYTE &&
      req_off == 2'h1 |=>
      cpu_rdata_out[7:0] == $past(bus_rdata_in[15:8]);
  endproperty
  a_off1_little: assert property (p_off1_little)
    else $error("little offset-1 byte not from 15-8");

  property p_zero_fill;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    state == ebl_pkg::EBL_WAIT && bus_ack_in && !req_fetch &&
      !req_signed && req_size == `EBL_SIZE_BYTE |=>
      cpu_done_out && cpu_rdata_out[31:8] == 24'h00_0000;
  endproperty
  a_zero_fill: assert property (p_zero_fill)
    else $error("unsigned byte load not zero filled");

  property p_fetch_word;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    state == ebl_pkg::EBL_WAIT && bus_ack_in && req_fetch &&
      !swap_on_out |=> cpu_rdata_out == $past(bus_rdata_in);
  endproperty
  a_fetch_word: assert property (p_fetch_word)
    else $error("fetch word altered");

  property p_word_bits;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    accept && cpu_size_in == `EBL_SIZE_WORD && !swap_on_out |=>
      bus_wdata_out == $past(cpu_wdata_in) && bus_be_out == `EBL_BE_ALL;
  endproperty
  a_word_bits: assert property (p_word_bits)
    else $error("word write bit numbering changed");

  property p_swap_map;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    accept && swap_on_out && cpu_size_in == `EBL_SIZE_WORD |=>
      bus_wdata_out[31:24] == $past(cpu_wdata_in[7:0]) &&
      bus_wdata_out[7:0] == $past(cpu_wdata_in[31:24]);
  endproperty
  a_swap_map: assert property (p_swap_map)
    else $error("swapper lane map wrong");

endmodule : ebl_steer

`default_nettype wire

//--- ebl_bus_model.sv
// Behavioural IO bus partner: a 16-word memory answering one request at
// a time with a one-cycle acknowledge after a random wait of 0 to 3.
// Assumes the steering unit holds its bus fields until the acknowledge.
`timescale 1ns/1ps
`default_nettype none

module ebl_bus_model (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // Bus request
  input  wire logic        bus_req_in,
  input  wire logic        bus_write_in,
  input  wire logic [31:0] bus_addr_in,
  input  wire logic [3:0]  bus_be_in,
  input  wire logic [31:0] bus_wdata_in,
  // Bus answer
  output logic             bus_ack_out,
  output logic      [31:0] bus_rdata_out
);
  logic [31:0] mem [0:15];
  int          wait_cnt;

  // Memory lanes keep bit numbering; read data is scrambled when idle
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_ack_out   <= 1'b0;
      bus_rdata_out <= 32'h0;
      wait_cnt      <= 0;
    end else if (bus_ack_out) begin
      bus_ack_out   <= 1'b0;
      bus_rdata_out <= ~bus_rdata_out;
    end else if (bus_req_in && wait_cnt == 0) begin
      bus_ack_out   <= 1'b1;
      bus_rdata_out <= mem[bus_addr_in[5:2]];
      wait_cnt      <= int'($urandom_range(3, 0));
      for (int i = 0; i < 4; i++) begin
        if (bus_write_in && bus_be_in[i]) begin
          mem[bus_addr_in[5:2]][8*i +: 8] <= bus_wdata_in[8*i +: 8];
        end
      end
    end else begin
      wait_cnt      <= bus_req_in ? wait_cnt - 1 : wait_cnt;
      bus_rdata_out <= ~bus_rdata_out;
    end
  end
endmodule : ebl_bus_model

`default_nettype wire

//--- tb_endian_byte_lane_swapper.sv
// Self-checking bench for the steering unit in all four strap settings.
// Assumes the bus partner model holds the external memory.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_endian_byte_lane_swapper;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        big = 1'b0, swp = 1'b0, req = 1'b0;
  logic        fet = 1'b0, wr = 1'b0, sgn = 1'b0;
  logic [1:0]  sz = 2'h0;
  logic [31:0] addr = 32'h0, wd = 32'h0;
  logic        rdy, done, beo, swo, breq, bwr, back;
  logic [1:0]  bsz;
  logic [3:0]  bbe;
  logic [31:0] rd, baddr, bwd, mrd;
  int          miscompares = 0;
  int          comparisons = 0;
  logic [31:0] shadow [0:15];
  logic        m_big, m_swp;
  logic [70:0] q_bus[$];
  logic [32:0] q_rd[$];
  logic [70:0] eb;
  logic [32:0] er;

  always #25 clk_sys_in = ~clk_sys_in;

  ebl_steer i_dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .cfg_big_endian_in(big), .cfg_swap_in(swp),
    .cpu_req_in(req), .cpu_fetch_in(fet), .cpu_write_in(wr),
    .cpu_signed_in(sgn), .cpu_size_in(sz), .cpu_addr_in(addr),
    .cpu_wdata_in(wd), .cpu_ready_out(rdy), .cpu_done_out(done),
    .cpu_rdata_out(rd), .big_endian_out(beo), .swap_on_out(swo),
    .bus_req_out(breq), .bus_write_out(bwr), .bus_size_out(bsz),
    .bus_addr_out(baddr), .bus_be_out(bbe), .bus_wdata_out(bwd),
    .bus_ack_in(back), .bus_rdata_in(mrd));

  ebl_bus_model i_bus (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .bus_req_in(breq), .bus_write_in(bwr), .bus_addr_in(baddr),
    .bus_be_in(bbe), .bus_wdata_in(bwd), .bus_ack_out(back),
    .bus_rdata_out(mrd));

  function automatic logic [31:0] rev(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : rev

  // One processor transfer; expectations are noted when it is taken
  task automatic xfer(input logic f, w, s, input logic [1:0] z,
                      input logic [31:0] a, d);
    logic [3:0]  pbe, ebe;
    logic [31:0] pw, ew, res;
    logic [15:0] h;
    int          ln, n;
    begin
      @(negedge clk_sys_in);
      fet = f; wr = w; sgn = s; sz = z; addr = a; wd = d; req = 1'b1;
      ln  = m_big ? 3 - int'(a[1:0]) : int'(a[1:0]);
      pbe = (f || z == 2'h2) ? 4'hF : (z == 2'h1) ?
            ((m_big ^ a[1]) ? 4'hC : 4'h3) : 4'(4'h1 << ln);
      ebe = m_swp ? {pbe[0], pbe[1], pbe[2], pbe[3]} : pbe;
      pw  = m_swp ? rev(shadow[a[5:2]]) : shadow[a[5:2]];
      h   = (m_big ^ a[1]) ? pw[31:16] : pw[15:0];
      res = (f || z == 2'h2) ? pw : (z == 2'h1) ? {{16{s & h[15]}}, h} :
            {{24{s & pw[8*ln+7]}}, pw[8*ln +: 8]};
      ew  = (z == 2'h0) ? {4{d[7:0]}} : (z == 2'h1) ? {2{d[15:0]}} : d;
      ew  = m_swp ? rev(ew) : ew;
      n   = 0;
      while (!rdy && n < 50) begin
        @(negedge clk_sys_in);
        n++;
      end
      // A request never taken counts against the run
      if (!rdy) miscompares++;
      q_bus.push_back({ew, w & ~f, f ? 2'h2 : z, ebe, a});
      q_rd.push_back({~(w & ~f), res});
      for (int i = 0; i < 4; i++) begin
        if (w && !f && ebe[i]) shadow[a[5:2]][8*i +: 8] = ew[8*i +: 8];
      end
      @(negedge clk_sys_in);
      req = 1'b0;
    end
  endtask : xfer

  // Bus side: each acknowledged transfer meets the oldest note
  always @(posedge clk_sys_in) begin
    if (breq && back) begin
      eb = q_bus.pop_front();
      `CHK("bus_be", eb[35:32], bbe)
      `CHK("bus_size", eb[37:36], bsz)
      `CHK("bus_addr", eb[31:0], baddr)
      `CHK("bus_write", eb[38], bwr)
      if (eb[38]) `CHK("bus_wdata", eb[70:39], bwd)
    end
  end

  // Processor side: load results are checked on each completion
  always @(posedge clk_sys_in) begin
    if (done) begin
      er = q_rd.pop_front();
      if (er[32]) `CHK("cpu_rdata", er[31:0], rd)
    end
  end

  // Reset with new straps, then fill, probe offsets, fetch and mix
  task automatic run_mode(input logic b, s);
    logic [31:0] a;
    logic [1:0]  z;
    begin
      // Let the last transfer finish so no note is orphaned by reset
      repeat (10) @(negedge clk_sys_in);
      sys_rst_in = 1'b1; big = b; swp = s; m_big = b; m_swp = s;
      repeat (2) @(negedge clk_sys_in);
      sys_rst_in = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      // Straps move after latching and must be ignored
      big = ~b; swp = ~s;
      `CHK("big_endian", b, beo)
      `CHK("swap_on", s, swo)
      for (int i = 0; i < 16; i++) xfer(0, 1, 0, 2'h2, 32'(i * 4), $urandom);
      for (int i = 0; i < 4; i++) xfer(0, 0, 0, 2'h0, 32'(4 + i), 32'h0);
      xfer(1, 1, 0, 2'h0, 32'h8, 32'h0);
      repeat (40) begin
        z = 2'($urandom_range(2, 0));
        a = 32'($urandom_range(63, 0));
        if (z == 2'h1) a[0] = 1'b0;
        if (z == 2'h2) a[1:0] = 2'h0;
        xfer(0, 1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)), z, a,
             $urandom);
      end
    end
  endtask : run_mode

  task automatic test_done;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask : test_done

  // Main sequence over every strap combination
  initial begin
    void'($urandom(32'h163B));
    repeat (12) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    run_mode(0, 0);
    run_mode(1, 0);
    run_mode(0, 1);
    run_mode(1, 1);
    repeat (10) @(negedge clk_sys_in);
    if (q_rd.size() != 0 || q_bus.size() != 0) miscompares++;
    test_done;
  end

  // Watchdog well beyond the expected run of well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    miscompares++;
    test_done;
  end
endmodule : tb_endian_byte_lane_swapper

`default_nettype wire
